// >>> common/sarith_cfg.svh
// Constants for the saturating arithmetic unit: widths, lane sizes, reset values.
// Assumes inclusion by bare name from the package and design files.
`ifndef SARITH_CFG_SVH
`define SARITH_CFG_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define SARITH_WORD_W      32
`define SARITH_HALF_W      16
`define SARITH_BYTE_W      8
`define SARITH_OP_W        4

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SARITH_RST_RESULT  32'h0000_0000
`define SARITH_RST_SAT     1'b0

`endif

// >>> common/sarith_pkg.sv
// Types shared by the saturating arithmetic unit and its self-checking bench.
// Assumes sarith_cfg.svh is on the include path.
`include "sarith_cfg.svh"

package sarith_pkg;

	// ----------------------------------------------------------------
	// Operation select
	// ----------------------------------------------------------------
	typedef enum logic [`SARITH_OP_W-1:0] {
		SARITH_OP_NONE                  = 4'h0,
		SARITH_OP_SAT_DOUBLE_ADD        = 4'h1,
		SARITH_OP_SAT_DOUBLE_SUB        = 4'h2,
		SARITH_OP_USAT_ADD_SUB_EXCHANGE = 4'h3,
		SARITH_OP_USAT_SUB_ADD_EXCHANGE = 4'h4,
		SARITH_OP_USAT_ADD_HALVES       = 4'h5,
		SARITH_OP_USAT_ADD_BYTES        = 4'h6,
		SARITH_OP_USAT_SUB_HALVES       = 4'h7,
		SARITH_OP_USAT_SUB_BYTES        = 4'h8
	} sarith_op_t;

	// ----------------------------------------------------------------
	// Request and answer carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		sarith_op_t                 op;
		logic [`SARITH_WORD_W-1:0]  opa;
		logic [`SARITH_WORD_W-1:0]  opb;
	} sarith_req_t;

	typedef struct packed {
		logic                       valid;
		logic [`SARITH_WORD_W-1:0]  result;
		logic                       sat_event;
	} sarith_rsp_t;

endpackage

// >>> design/sarith_lane.sv
// One unsigned saturating lane: add or subtract with a guard bit, clamp to range.
// Assumes operands are unsigned lane values; purely combinational.
`timescale 1ns/1ps

module sarith_lane #(
	parameter int W = 16
) (
	// Operands
	input  wire logic [W-1:0] i_a,
	input  wire logic [W-1:0] i_b,
	input  wire logic         i_sub,
	// Answer
	output logic [W-1:0]      o_y
);
	// ----------------------------------------------------------------
	// Guarded arithmetic
	// ----------------------------------------------------------------
	logic [W:0] ext;     // One extra bit catches carry or borrow

	always_comb begin
		// Extra bit makes the clamp exact
		ext = i_sub ? ({1'b0, i_a} - {1'b0, i_b}) : ({1'b0, i_a} + {1'b0, i_b});
		if (ext[W]) begin
			// Borrow clamps to zero, carry clamps to all ones
			o_y = i_sub ? '0 : '1;
		end else begin
			o_y = ext[W-1:0];
		end
	end
endmodule

// >>> design/sarith_unit.sv
// Saturating arithmetic slice: doubling signed add/sub and packed unsigned ops.
// Assumes decode gives one request per valid cycle and holds the write strobe for clears.
//
// Summary of operation
// - Doubling add: first plus doubled second
// - Doubling subtract: first minus doubled second
// - Clamp doubling and result to signed 32
// - Any clamp in doubling sets saturation flag
// - Flag sticks until software clears it
// - Add-sub exchange top: hi(a)+lo(b) clamped
// - Add-sub exchange bottom: lo(a)-hi(b) clamped
// - Sub-add exchange top: hi(a)-lo(b) clamped
// - Sub-add exchange bottom: lo(a)+hi(b) clamped
// - Halfword add, each lane clamped unsigned
// - Byte add, each lane clamped unsigned
// - Halfword subtract, negatives clamp to zero
// - Byte subtract, lanes clamped zero to 255
// - Unsigned ops leave condition flags alone
`timescale 1ns/1ps
`include "sarith_cfg.svh"

module sarith_unit
	import sarith_pkg::*;
#(
	parameter int WORD_W = `SARITH_WORD_W
) (
	// Clock and reset
	input  wire logic              i_clk_sys,
	input  wire logic              i_rst,
	// Request from decode
	input  wire logic              i_valid,
	input  wire sarith_req_t       i_req,
	// Status word write for the saturation flag
	input  wire logic              i_sat_wr,
	input  wire logic              i_sat_wdata,
	// Writeback
	output logic                   o_valid,
	output logic [WORD_W-1:0]      o_result,
	output logic                   o_sat_event,
	output logic                   o_flags_we,
	// Sticky saturation flag
	output logic                   o_sat_flag
);
	// ----------------------------------------------------------------
	// Constants
	// ----------------------------------------------------------------
	localparam int HW = `SARITH_HALF_W;   // Halfword lane width
	localparam int BW = `SARITH_BYTE_W;   // Byte lane width
	localparam logic [WORD_W-1:0] SMAX = {1'b0, {(WORD_W-1){1'b1}}}; // Largest signed
	localparam logic [WORD_W-1:0] SMIN = {1'b1, {(WORD_W-1){1'b0}}}; // Smallest signed

	// ----------------------------------------------------------------
	// Doubling path
	// ----------------------------------------------------------------
	logic [WORD_W-1:0] dbl;        // Clamped doubled second operand
	logic              dbl_sat;    // Doubling clamped
	logic [WORD_W:0]   acc;        // Guarded sum or difference
	logic [WORD_W-1:0] dres;       // Clamped doubling result
	logic              dres_sat;   // Final step clamped
	logic              is_dsub;    // Subtract flavour

	always_comb begin
		is_dsub = (i_req.op == SARITH_OP_SAT_DOUBLE_SUB);
		// Doubling overflows when the two top bits differ
		dbl_sat = i_req.opb[WORD_W-1] ^ i_req.opb[WORD_W-2];
		if (dbl_sat) begin
			dbl = i_req.opb[WORD_W-1] ? SMIN : SMAX;
		end else begin
			dbl = {i_req.opb[WORD_W-2:0], 1'b0};
		end
		// Sign extended by one bit to see the overflow
		if (is_dsub) begin
			acc = {i_req.opa[WORD_W-1], i_req.opa} - {dbl[WORD_W-1], dbl};
		end else begin
			acc = {i_req.opa[WORD_W-1], i_req.opa} + {dbl[WORD_W-1], dbl};
		end
		dres_sat = acc[WORD_W] ^ acc[WORD_W-1];
		if (dres_sat) begin
			dres = acc[WORD_W] ? SMIN : SMAX;
		end else begin
			dres = acc[WORD_W-1:0];
		end
	end

	// ----------------------------------------------------------------
	// Packed unsigned lanes
	// ----------------------------------------------------------------
	logic [HW-1:0] h_a [2];    // Halfword lane first operands
	logic [HW-1:0] h_b [2];    // Halfword lane second operands
	logic          h_s [2];    // Halfword lane subtract select
	logic [HW-1:0] h_y [2];    // Halfword lane answers
	logic [BW-1:0] b_y [4];    // Byte lane answers
	logic          b_sub;      // Byte lanes subtract

	always_comb begin
		// Default straight lanes: add
		h_a[1] = i_req.opa[2*HW-1:HW];
		h_a[0] = i_req.opa[HW-1:0];
		h_b[1] = i_req.opb[2*HW-1:HW];
		h_b[0] = i_req.opb[HW-1:0];
		h_s[1] = 1'b0;
		h_s[0] = 1'b0;
		b_sub  = (i_req.op == SARITH_OP_USAT_SUB_BYTES);
		unique case (i_req.op)
			SARITH_OP_USAT_ADD_SUB_EXCHANGE: begin
				h_b[1] = i_req.opb[HW-1:0];
				h_b[0] = i_req.opb[2*HW-1:HW];
				h_s[0] = 1'b1;
			end
			SARITH_OP_USAT_SUB_ADD_EXCHANGE: begin
				h_b[1] = i_req.opb[HW-1:0];
				h_b[0] = i_req.opb[2*HW-1:HW];
				h_s[1] = 1'b1;
			end
			SARITH_OP_USAT_SUB_HALVES: begin
				h_s[1] = 1'b1;
				h_s[0] = 1'b1;
			end
			default: begin
				// Straight halfword add, also harmless for other ops
				h_s[1] = 1'b0;
			end
		endcase
	end

	// Lanes share one slice module; exchange only changes operand steering
	generate
		for (genvar gh = 0; gh < 2; gh++) begin : g_half
			sarith_lane #(.W(HW)) u_lane (
				.i_a   (h_a[gh]),
				.i_b   (h_b[gh]),
				.i_sub (h_s[gh]),
				.o_y   (h_y[gh])
			);
		end
		for (genvar gb = 0; gb < 4; gb++) begin : g_byte
			// Each byte lane independent, no carry between lanes
			sarith_lane #(.W(BW)) u_lane (
				.i_a   (i_req.opa[gb*BW +: BW]),
				.i_b   (i_req.opb[gb*BW +: BW]),
				.i_sub (b_sub),
				.o_y   (b_y[gb])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Result select and sticky flag
	// ----------------------------------------------------------------
	logic              valid_ff,  nxt_valid;   // Answer valid
	logic [WORD_W-1:0] result_ff, nxt_result;  // Registered result
	logic              event_ff,  nxt_event;   // Saturated this answer
	logic              sat_ff,    nxt_sat;     // Sticky saturation flag
	logic              flags_ff,  nxt_flags;   // Condition flags write, held low
	logic              is_dbl;                 // Doubling request

	always_comb begin
		is_dbl     = i_valid && (i_req.op == SARITH_OP_SAT_DOUBLE_ADD || is_dsub);
		nxt_valid  = i_valid && (i_req.op != SARITH_OP_NONE);
		nxt_event  = is_dbl && (dbl_sat || dres_sat);
		// Condition flags never written by this slice
		nxt_flags  = 1'b0;
		nxt_result = result_ff;
		if (i_valid) begin
			unique case (i_req.op)
				SARITH_OP_SAT_DOUBLE_ADD,
				SARITH_OP_SAT_DOUBLE_SUB:        nxt_result = dres;
				SARITH_OP_USAT_ADD_BYTES,
				SARITH_OP_USAT_SUB_BYTES:        nxt_result = {b_y[3], b_y[2], b_y[1], b_y[0]};
				SARITH_OP_NONE:                  nxt_result = result_ff;
				default:                         nxt_result = {h_y[1], h_y[0]};
			endcase
		end
		// Software write first, hardware set wins in same cycle
		nxt_sat = sat_ff;
		if (i_sat_wr) begin
			nxt_sat = i_sat_wdata;
		end
		if (nxt_event) begin
			nxt_sat = 1'b1;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			valid_ff  <= 1'b0;
			result_ff <= `SARITH_RST_RESULT;
			event_ff  <= 1'b0;
			sat_ff    <= `SARITH_RST_SAT;
			flags_ff  <= 1'b0;
		end else begin
			valid_ff  <= nxt_valid;
			result_ff <= nxt_result;
			event_ff  <= nxt_event;
			sat_ff    <= nxt_sat;
			flags_ff  <= nxt_flags;
		end
	end

	// Every output straight from a flip-flop
	assign o_flags_we  = flags_ff;
	assign o_valid     = valid_ff;
	assign o_result    = result_ff;
	assign o_sat_event = event_ff;
	assign o_sat_flag  = sat_ff;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	// Both terms below a quarter of the range, so neither step can clamp
	property p_dadd;
		@(posedge i_clk_sys) disable iff (i_rst)
		(i_valid && i_req.op == SARITH_OP_SAT_DOUBLE_ADD && !i_req.opb[31] && !i_req.opb[30] && !i_req.opb[29]
		 && !i_req.opa[31] && !i_req.opa[30]) |=> (o_result == $past(i_req.opa) + {$past(i_req.opb[30:0]), 1'b0});
	endproperty
	a_dadd: assert property (p_dadd) else $error("doubling add result wrong");

	property p_dsub_zero;
		@(posedge i_clk_sys) disable iff (i_rst)
		(i_valid && i_req.op == SARITH_OP_SAT_DOUBLE_SUB && i_req.opb == 32'h0000_0000)
		|=> (o_result == $past(i_req.opa)) && !o_sat_event;
	endproperty
	a_dsub_zero: assert property (p_dsub_zero) else $error("doubling sub by zero wrong");

	property p_dbl_clamp;
		@(posedge i_clk_sys) disable iff (i_rst)
		(i_valid && i_req.op == SARITH_OP_SAT_DOUBLE_ADD && i_req.opb == 32'h7FFF_FFFF && !i_req.opa[31])
		|=> (o_result == 32'h7FFF_FFFF) && o_sat_event;
	endproperty
	a_dbl_clamp: assert property (p_dbl_clamp) else $error("signed clamp wrong");

	property p_flag_set;
		@(posedge i_clk_sys) disable iff (i_rst)
		o_sat_event |-> o_sat_flag;
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("flag not set on saturation");

	property p_flag_sticky;
		@(posedge i_clk_sys) disable iff (i_rst)
		(o_sat_flag && !i_sat_wr) |=> o_sat_flag;
	endproperty
	a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped without write");

	property p_asx;
		@(posedge i_clk_sys) disable iff (i_rst)
		(i_valid && i_req.op == SARITH_OP_USAT_ADD_SUB_EXCHANGE && i_req.opa[15:0] < i_req.opb[31:16])
		|=> (o_result[15:0] == 16'h0000);
	endproperty
	a_asx: assert property (p_asx) else $error("exchange bottom not clamped");

	property p_sax;
		@(posedge i_clk_sys) disable iff (i_rst)
		(i_valid && i_req.op == SARITH_OP_USAT_SUB_ADD_EXCHANGE && i_req.opa[31:16] >= i_req.opb[15:0])
		|=> (o_result[31:16] == $past(i_req.opa[31:16]) - $past(i_req.opb[15:0]));
	endproperty
	a_sax: assert property (p_sax) else $error("exchange top difference wrong");

	property p_add_bytes;
		@(posedge i_clk_sys) disable iff (i_rst)
		(i_valid && i_req.op == SARITH_OP_USAT_ADD_BYTES && i_req.opa[7:0] == 8'hFF && i_req.opb[7:0] != 8'h00)
		|=> (o_result[7:0] == 8'hFF) && !o_sat_event;
	endproperty
	a_add_bytes: assert property (p_add_bytes) else $error("byte add clamp wrong");

	property p_sub_halves;
		@(posedge i_clk_sys) disable iff (i_rst)
		(i_valid && i_req.op == SARITH_OP_USAT_SUB_HALVES && i_req.opa[31:16] < i_req.opb[31:16])
		|=> (o_result[31:16] == 16'h0000);
	endproperty
	a_sub_halves: assert property (p_sub_halves) else $error("halfword sub clamp wrong");

	property p_noflags;
		@(posedge i_clk_sys) disable iff (i_rst)
		o_valid |-> !o_flags_we;
	endproperty
	a_noflags: assert property (p_noflags) else $error("condition flags touched");

	c_dsat:  cover property (@(posedge i_clk_sys) disable iff (i_rst) o_sat_event);
	c_clear: cover property (@(posedge i_clk_sys) disable iff (i_rst) o_sat_flag ##1 !o_sat_flag);
	c_bytes: cover property (@(posedge i_clk_sys) disable iff (i_rst)
		i_valid && i_req.op == SARITH_OP_USAT_SUB_BYTES ##1 o_valid);
	c_xchg:  cover property (@(posedge i_clk_sys) disable iff (i_rst)
		i_valid && i_req.op == SARITH_OP_USAT_ADD_SUB_EXCHANGE ##1 o_valid);
endmodule

// >>> verification/sarith_wb_model.sv
// Writeback model: stores every answer the unit hands back, counts answers.
// Assumes one clock and a synchronous active-high reset shared with the unit.
`timescale 1ns/1ps

module sarith_wb_model (
	// Clock and reset
	input  wire logic        i_clk_sys,
	input  wire logic        i_rst,
	// Answer from the unit
	input  wire logic        i_valid,
	input  wire logic [31:0] i_result,
	input  wire logic        i_flags_we,
	// Register file view
	output logic [31:0]      o_last,
	output logic [15:0]      o_count,
	output logic             o_flags_hit
);
	// ----------------------------------------------------------------
	// Destination register and bookkeeping
	// ----------------------------------------------------------------
	logic [31:0] last_ff;   // Last written destination value
	logic [15:0] count_ff;  // Answers seen since reset
	logic        hit_ff;    // Condition flags were ever written
	// Writes only on a valid answer, like a real register file port
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			last_ff  <= 32'h0;
			count_ff <= 16'h0;
			hit_ff   <= 1'b0;
		end else begin
			if (i_valid) begin
				last_ff  <= i_result;
				count_ff <= count_ff + 16'h1;
			end
			hit_ff <= hit_ff | i_flags_we;
		end
	end
	assign o_last      = last_ff;
	assign o_count     = count_ff;
	assign o_flags_hit = hit_ff;
endmodule

// >>> verification/saturating_arith_unit_test.sv
// Self-checking bench for the saturating arithmetic unit with a writeback model.
// Assumes the unit answers one cycle after each taken request.
`timescale 1ns/1ps

module saturating_arith_unit_test
	import sarith_pkg::*;
;
	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic        i_clk_sys = 1'b0;  // 200 MHz clock
	logic        i_rst     = 1'b1;  // Held for 16 cycles
	logic        i_valid   = 1'b0;
	sarith_req_t i_req     = '0;
	logic        i_sat_wr  = 1'b0;
	logic        i_sat_wdata = 1'b0;
	logic        o_valid, o_sat_event, o_flags_we, o_sat_flag, wb_hit;
	logic [31:0] o_result, wb_last;
	logic [15:0] wb_count;
	int          num_errors = 0;
	int          n_tests    = 0;
	int          cycles     = 0;

	always #2.5 i_clk_sys = ~i_clk_sys;

	sarith_unit i_dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_valid(i_valid), .i_req(i_req),
		.i_sat_wr(i_sat_wr), .i_sat_wdata(i_sat_wdata), .o_valid(o_valid), .o_result(o_result),
		.o_sat_event(o_sat_event), .o_flags_we(o_flags_we), .o_sat_flag(o_sat_flag));
	sarith_wb_model i_wb (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_valid(o_valid), .i_result(o_result),
		.i_flags_we(o_flags_we), .o_last(wb_last), .o_count(wb_count), .o_flags_hit(wb_hit));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Four-state compare so an unknown never matches
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic complete_run();
		$display("tests %0d errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Hang guard, far above the roughly 62 cycles needed
	always @(posedge i_clk_sys) begin
		cycles++;
		if (cycles == 3000) begin
			num_errors++;
			complete_run();
		end
	end

	// One request, answer judged in its only valid cycle
	task automatic issue(input sarith_op_t op, input logic [31:0] a, b, r, input logic ev);
		@(negedge i_clk_sys);
		i_valid = 1'b1;
		i_req   = '{op: op, opa: a, opb: b};
		@(negedge i_clk_sys);
		i_valid = 1'b0;
		check("valid", {31'h0, o_valid}, 32'h1);
		check("result", o_result, r);
		check("sat_event", {31'h0, o_sat_event}, {31'h0, ev});
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	// Doubling ops, both clamp points, and flag stickiness
	task automatic t_double();
		issue(SARITH_OP_SAT_DOUBLE_ADD, 32'h0000_000A, 32'h0000_0003, 32'h0000_0010, 1'b0);
		check("flag", {31'h0, o_sat_flag}, 32'h0);
		issue(SARITH_OP_SAT_DOUBLE_ADD, 32'h0000_0000, 32'h7FFF_FFFF, 32'h7FFF_FFFF, 1'b1);
		check("flag", {31'h0, o_sat_flag}, 32'h1);
		issue(SARITH_OP_SAT_DOUBLE_SUB, 32'h0000_0064, 32'h0000_001E, 32'h0000_0028, 1'b0);
		issue(SARITH_OP_SAT_DOUBLE_SUB, 32'h8000_0000, 32'h0000_0000, 32'h8000_0000, 1'b0);
		check("flag", {31'h0, o_sat_flag}, 32'h1);
		// Doubling exactly reaches the minimum, only the subtract clamps
		issue(SARITH_OP_SAT_DOUBLE_SUB, 32'h0000_0000, 32'hC000_0000, 32'h7FFF_FFFF, 1'b1);
		issue(SARITH_OP_SAT_DOUBLE_SUB, 32'h8000_0000, 32'h0000_0001, 32'h8000_0000, 1'b1);
		// Doubling clamps to minimum, then the add stays in range
		issue(SARITH_OP_SAT_DOUBLE_ADD, 32'h7FFF_FFFF, 32'h8000_0000, 32'hFFFF_FFFF, 1'b1);
	endtask

	// Software clear of the sticky flag
	task automatic t_clear();
		@(negedge i_clk_sys);
		i_sat_wr    = 1'b1;
		i_sat_wdata = 1'b0;
		@(negedge i_clk_sys);
		i_sat_wr = 1'b0;
		check("flag_clr", {31'h0, o_sat_flag}, 32'h0);
		// Saturation in the same cycle as a clear: the set wins
		@(negedge i_clk_sys);
		i_sat_wr = 1'b1;
		i_valid  = 1'b1;
		i_req    = '{op: SARITH_OP_SAT_DOUBLE_ADD, opa: 32'h7FFF_FFFF, opb: 32'h0000_0001};
		@(negedge i_clk_sys);
		i_sat_wr = 1'b0;
		i_valid  = 1'b0;
		check("win_result", o_result, 32'h7FFF_FFFF);
		check("flag_win", {31'h0, o_sat_flag}, 32'h1);
		@(negedge i_clk_sys);
		i_sat_wr = 1'b1;
		@(negedge i_clk_sys);
		i_sat_wr = 1'b0;
		check("flag_clr2", {31'h0, o_sat_flag}, 32'h0);
	endtask

	// Mid-run reset clears result and sticky flag
	task automatic t_reset();
		issue(SARITH_OP_SAT_DOUBLE_SUB, 32'h8000_0000, 32'h4000_0000, 32'h8000_0000, 1'b1);
		@(negedge i_clk_sys);
		i_rst = 1'b1;
		@(negedge i_clk_sys);
		i_rst = 1'b0;
		check("rst2_result", o_result, 32'h0);
		check("rst2_flag", {31'h0, o_sat_flag}, 32'h0);
	endtask

	// Exchange and packed ops; lane picks chosen so a swapped lane shows
	task automatic t_unsigned();
		issue(SARITH_OP_USAT_ADD_SUB_EXCHANGE, 32'hFFF0_0005, 32'h0003_0020, 32'hFFFF_0002, 1'b0);
		issue(SARITH_OP_USAT_ADD_SUB_EXCHANGE, 32'h0001_0002, 32'h0007_0004, 32'h0005_0000, 1'b0);
		issue(SARITH_OP_USAT_SUB_ADD_EXCHANGE, 32'h0030_FFD0, 32'h0020_0040, 32'h0000_FFF0, 1'b0);
		issue(SARITH_OP_USAT_SUB_ADD_EXCHANGE, 32'h0050_FFF0, 32'h0040_0010, 32'h0040_FFFF, 1'b0);
		issue(SARITH_OP_USAT_ADD_HALVES, 32'hFFFF_1234, 32'h0001_1111, 32'hFFFF_2345, 1'b0);
		issue(SARITH_OP_USAT_ADD_BYTES, 32'hFF7F_0102, 32'h0180_FE03, 32'hFFFF_FF05, 1'b0);
		issue(SARITH_OP_USAT_SUB_HALVES, 32'h0005_8000, 32'h0006_0001, 32'h0000_7FFF, 1'b0);
		issue(SARITH_OP_USAT_SUB_BYTES, 32'h0010_FF00, 32'h0011_0001, 32'h0000_FF00, 1'b0);
		issue(SARITH_OP_USAT_ADD_BYTES, 32'h8000_00FF, 32'h8000_0001, 32'hFF00_00FF, 1'b0);
		check("flag_u", {31'h0, o_sat_flag}, 32'h0);
		check("flags_hit", {31'h0, wb_hit}, 32'h0);
	endtask

	// Back-to-back requests, then an idle op that gives no answer
	task automatic t_b2b();
		@(negedge i_clk_sys);
		i_valid = 1'b1;
		i_req   = '{op: SARITH_OP_USAT_ADD_HALVES, opa: 32'h0001_0002, opb: 32'h0003_0004};
		@(negedge i_clk_sys);
		i_req   = '{op: SARITH_OP_USAT_SUB_HALVES, opa: 32'h0001_0002, opb: 32'h0003_0001};
		check("b2b_0", o_result, 32'h0004_0006);
		@(negedge i_clk_sys);
		i_req   = '{op: SARITH_OP_NONE, opa: 32'h0, opb: 32'h0};
		check("b2b_1", o_result, 32'h0000_0001);
		check("b2b_v", {31'h0, o_valid}, 32'h1);
		@(negedge i_clk_sys);
		i_valid = 1'b0;
		check("none_v", {31'h0, o_valid}, 32'h0);
		check("wb_last", wb_last, 32'h0000_0001);
		check("wb_count", {16'h0, wb_count}, 32'h0000_0013);
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (16) @(negedge i_clk_sys);
		i_rst = 1'b0;
		check("rst_result", o_result, 32'h0);
		check("rst_flag", {31'h0, o_sat_flag}, 32'h0);
		t_double();
		t_clear();
		t_unsigned();
		t_b2b();
		t_reset();
		complete_run();
	end
endmodule
